// [src/uart_core.sv]
// How it works
// RULE1: Transmit enable counts only after module enable
// RULE2: Enabling transmit raises transmit interrupt flag
// RULE3: Software writes words until buffer full
// RULE4: Break is start, twelve zeros, stop
// RULE5: Dummy write with send-break starts break frame
// RULE6: Send-break self-clears after break stop bit
// RULE7: Software sets break only when shifter empty
// RULE8: Break frame never raises transmit interrupt
// RULE9: Send-break overrides other transmit activity
// RULE10: Shift-empty flag behaves normally during break
// RULE11: Break, dummy write, then sync byte
// RULE12: 16x mode votes samples 7, 8, 9
// RULE13: 4x mode samples once mid-bit
// RULE14: Stop sample moves shifted word to FIFO
// RULE15: Receive FIFO holds four nine-bit words
// RULE16: Fifth word with full FIFO sets overrun
// RULE17: Overrun holds word, blocks transfers and interrupts
// RULE18: Clearing overrun empties the receive FIFO
// RULE19: Low stop bit sets framing error
// RULE20: Parity error reflects head word
// RULE21: Error flags stored beside each word
// RULE22: Errors raise error interrupt when enabled
// RULE23: Select field chooses transmit interrupt event
// RULE24: Data available while FIFO holds words
// RULE25: Output line high between frames
// RULE26: Parity checked with chosen even/odd sense
`default_nettype none
module uart_core import uart_pkg::*; (
    // Clock, reset, clock enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Configuration
    input wire logic module_enable_i,
    input wire logic tx_enable_i,
    input wire logic high_speed_select_i,
    input wire logic [1:0] format_parity_select_i,
    input wire logic stop_count_select_i,
    input wire logic [1:0] tx_irq_select_i,
    input wire logic [15:0] baud_divisor_i,
    input wire logic error_irq_enable_i,
    // Transmit software side
    input wire logic send_break_set_i,
    input wire logic tx_irq_clear_i,
    input wire logic tx_write_i,
    input wire logic [8:0] tx_data_i,
    output logic send_break_o,
    output logic tx_irq_flag_o,
    output logic tx_full_flag_o,
    output logic shift_empty_flag_o,
    // Receive software side
    input wire logic rx_read_i,
    input wire logic overrun_clear_i,
    output logic [8:0] rx_data_o,
    output logic [3:0] rx_status_o,
    output logic rx_irq_o,
    output logic error_irq_o,
    // Serial line
    input wire logic serial_input_line_i,
    output logic serial_output_line_o,
    output logic serial_output_oe_o
);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;

    logic [15:0] brg_r, brg_nxt;
    logic tick;
    logic [3:0] last;
    logic fmt9, fmt_par;

    assign tick = module_enable_i && (brg_r == baud_divisor_i);
    assign last = high_speed_select_i ? OVS_HI_LAST : OVS_LO_LAST;
    assign fmt9 = format_parity_select_i == FMT_9N;
    assign fmt_par = format_parity_select_i == FMT_8E || format_parity_select_i == FMT_8O;

    always_comb begin
        brg_nxt = (!module_enable_i || tick) ? 16'h0000 : brg_r + 16'h0001;
    end

    // Transmit
    stream_if #(.W(WORD_W)) txw ();
    stream_if #(.W(WORD_W)) txq ();
    logic [1:0] tx_count;
    tx_state_type tx_state_r, tx_state_nxt;
    logic [8:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_bits_r, tx_bits_nxt, tx_sub_r, tx_sub_nxt;
    logic tx_par_r, tx_par_nxt, tx_stops_r, tx_stops_nxt, tx_brk_r, tx_brk_nxt;
    logic send_break_r, send_break_nxt, tx_irq_r, tx_irq_nxt;
    logic txen_r, txen_nxt, txreq_q_r, line_r, line_nxt;
    logic bit_end, load, frame_end;

    assign txw.valid = tx_write_i && module_enable_i;
    assign txw.data = tx_data_i;
    assign tx_full_flag_o = !txw.ready; // [RULE3]
    assign bit_end = tick && tx_sub_r == last;
    // No load in the cycle that either enable drops, so an aborted frame eats no word
    assign txq.ready = tx_state_r == TX_IDLE && txen_r && module_enable_i && tx_enable_i;
    assign load = txq.valid && txq.ready;
    assign frame_end = tx_state_r == TX_STOP && bit_end && !tx_stops_r;

    word_fifo #(.W(WORD_W), .DEPTH(TX_DEPTH)) tx_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .flush_i(!module_enable_i),
        .in_s(txw),
        .out_s(txq),
        .count_o(tx_count)
    );

    always_comb begin
        // Enable only latches while the module is already on
        txen_nxt = module_enable_i && tx_enable_i
                   && (txen_r || !txreq_q_r); // [RULE1]
        tx_state_nxt = tx_state_r;
        tx_sh_nxt = tx_sh_r;
        tx_bits_nxt = tx_bits_r;
        tx_par_nxt = tx_par_r;
        tx_stops_nxt = tx_stops_r;
        tx_brk_nxt = tx_brk_r;
        tx_sub_nxt = (tick && tx_state_r != TX_IDLE) ? (bit_end ? 4'h0 : tx_sub_r + 4'h1)
                   : tx_sub_r;
        case (tx_state_r)
            TX_IDLE: begin
                tx_sub_nxt = 4'h0;
                if (load) begin
                    tx_state_nxt = TX_START;
                    // Break takes the dummy word and throws its value away
                    tx_brk_nxt = send_break_r; // [RULE5] [RULE9]
                    tx_sh_nxt = send_break_r ? 9'h000 : txq.data; // [RULE5]
                    tx_bits_nxt = send_break_r ? BRK_ZEROS : (fmt9 ? BITS9 : BITS8); // [RULE4]
                    tx_par_nxt = parity_bit(txq.data[7:0], format_parity_select_i == FMT_8O);
                    tx_stops_nxt = stop_count_select_i && !send_break_r; // [RULE4]
                end
            end
            TX_START: begin
                if (bit_end) tx_state_nxt = TX_DATA;
            end
            TX_DATA: begin
                if (bit_end) begin
                    tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
                    tx_bits_nxt = tx_bits_r - 4'h1;
                    if (tx_bits_r == 4'h1) tx_state_nxt = (!tx_brk_r && fmt_par) ? TX_PAR : TX_STOP;
                end
            end
            TX_PAR: begin
                if (bit_end) tx_state_nxt = TX_STOP;
            end
            TX_STOP: begin
                if (bit_end) begin
                    tx_stops_nxt = 1'b0;
                    if (!tx_stops_r) tx_state_nxt = TX_IDLE;
                end
            end
            default: tx_state_nxt = TX_IDLE;
        endcase
        // Dropping either enable aborts the frame on the same edge
        if (!txen_nxt) begin
            tx_state_nxt = TX_IDLE;
        end
        case (tx_state_nxt)
            TX_START: line_nxt = 1'b0;
            TX_DATA: line_nxt = tx_sh_nxt[0];
            TX_PAR: line_nxt = tx_par_nxt;
            default: line_nxt = 1'b1; // [RULE25]
        endcase
        // Hardware clear loses to a new set in the same cycle
        send_break_nxt = module_enable_i && (send_break_set_i
                         || (send_break_r && !(frame_end && tx_brk_r))); // [RULE6]
        tx_irq_nxt = (txen_nxt && !txen_r) // [RULE2]
                     || (load && !send_break_r && tx_irq_select_i == TXSEL_LOAD) // [RULE23]
                     || (load && !send_break_r && tx_count == 2'h1
                         && tx_irq_select_i == TXSEL_EMPTY) // [RULE23]
                     || (frame_end && !tx_brk_r && !txq.valid
                         && tx_irq_select_i == TXSEL_DONE) // [RULE23] [RULE8]
                     || (tx_irq_r && !tx_irq_clear_i);
    end

    assign send_break_o = send_break_r;
    assign tx_irq_flag_o = tx_irq_r;
    assign shift_empty_flag_o = tx_state_r == TX_IDLE; // [RULE10]
    assign serial_output_line_o = line_r;
    assign serial_output_oe_o = txen_r;

    // Receive
    stream_if #(.W(ENTRY_W)) rxw ();
    stream_if #(.W(ENTRY_W)) rxq ();
    logic [2:0] rx_count;
    rx_state_type rx_state_r, rx_state_nxt;
    logic [8:0] rx_sh_r, rx_sh_nxt, word;
    logic [3:0] rx_cnt_r, rx_cnt_nxt;
    logic rx_pbit_r, rx_pbit_nxt, ovr_r, ovr_nxt;
    logic rx_irq_r, rx_irq_nxt, err_irq_r, err_irq_nxt;
    logic start, strobe, rbit, stop_evt, framing_error_flag, parity_error_flag;

    rx_sampler sampler (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(module_enable_i && !ovr_r),
        .active_i(rx_state_r != RX_IDLE),
        .tick_i(tick),
        .high_speed_i(high_speed_select_i),
        .serial_i(serial_input_line_i),
        .start_o(start),
        .strobe_o(strobe),
        .bit_o(rbit)
    );

    // Four entries of data plus both error flags
    word_fifo #(.W(ENTRY_W), .DEPTH(RX_DEPTH)) rx_fifo ( // [RULE15] [RULE21]
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .flush_i(!module_enable_i || (ovr_r && overrun_clear_i)), // [RULE18]
        .in_s(rxw),
        .out_s(rxq),
        .count_o(rx_count)
    );

    assign stop_evt = rx_state_r == RX_STOP && strobe;
    assign word = fmt9 ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    assign framing_error_flag = !rbit; // [RULE19]
    assign parity_error_flag = fmt_par
                  && parity_bit(word[7:0], format_parity_select_i == FMT_8O) != rx_pbit_r; // [RULE26]
    // Stop sample hands the word over; valid lasts that single cycle
    assign rxw.valid = stop_evt && !ovr_r; // [RULE14] [RULE17]
    assign rxw.data = {parity_error_flag, framing_error_flag, word}; // [RULE21]
    assign rxq.ready = rx_read_i;

    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_pbit_nxt = rx_pbit_r;
        case (rx_state_r)
            RX_IDLE: begin
                if (start) rx_state_nxt = RX_START;
            end
            RX_START: begin
                if (strobe) begin
                    rx_state_nxt = rbit ? RX_IDLE : RX_DATA;
                    rx_cnt_nxt = fmt9 ? BITS9 : BITS8;
                end
            end
            RX_DATA: begin
                if (strobe) begin
                    rx_sh_nxt = {rbit, rx_sh_r[8:1]}; // [RULE14]
                    rx_cnt_nxt = rx_cnt_r - 4'h1;
                    if (rx_cnt_r == 4'h1) rx_state_nxt = fmt_par ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: begin
                if (strobe) begin
                    rx_pbit_nxt = rbit;
                    rx_state_nxt = RX_STOP;
                end
            end
            RX_STOP: begin
                if (strobe) rx_state_nxt = RX_IDLE;
            end
            default: rx_state_nxt = RX_IDLE;
        endcase
        if (!module_enable_i) begin
            rx_state_nxt = RX_IDLE;
        end
        ovr_nxt = module_enable_i && ((stop_evt && !rxw.ready) // [RULE16]
                                      || (ovr_r && !overrun_clear_i));
        rx_irq_nxt = rxw.valid && rxw.ready; // [RULE17]
        err_irq_nxt = error_irq_enable_i && stop_evt && !ovr_r
                      && (!rxw.ready || framing_error_flag || parity_error_flag); // [RULE22]
    end

    assign rx_data_o = rxq.data[8:0];
    assign rx_status_o[STAT_AVAIL] = rxq.valid; // [RULE24]
    assign rx_status_o[STAT_OVR] = ovr_r;
    assign rx_status_o[STAT_FRAMING_ERROR_FLAG] = rxq.valid && rxq.data[FRAMING_ERROR_FLAG_POS];
    assign rx_status_o[STAT_PARITY_ERROR_FLAG] = rxq.valid && rxq.data[PARITY_ERROR_FLAG_POS]; // [RULE20]
    assign rx_irq_o = rx_irq_r;
    assign error_irq_o = err_irq_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            brg_r <= 16'h0000;
            txen_r <= 1'b0;
            txreq_q_r <= 1'b0;
            tx_state_r <= TX_IDLE;
            tx_sh_r <= 9'h000;
            tx_bits_r <= 4'h0;
            tx_sub_r <= 4'h0;
            tx_par_r <= 1'b0;
            tx_stops_r <= 1'b0;
            tx_brk_r <= 1'b0;
            send_break_r <= 1'b0;
            tx_irq_r <= 1'b0;
            line_r <= 1'b1;
            rx_state_r <= RX_IDLE;
            rx_sh_r <= 9'h000;
            rx_cnt_r <= 4'h0;
            rx_pbit_r <= 1'b0;
            ovr_r <= 1'b0;
            rx_irq_r <= 1'b0;
            err_irq_r <= 1'b0;
        end else if (ce_i) begin
            brg_r <= brg_nxt;
            txen_r <= txen_nxt;
            txreq_q_r <= tx_enable_i;
            tx_state_r <= tx_state_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_bits_r <= tx_bits_nxt;
            tx_sub_r <= tx_sub_nxt;
            tx_par_r <= tx_par_nxt;
            tx_stops_r <= tx_stops_nxt;
            tx_brk_r <= tx_brk_nxt;
            send_break_r <= send_break_nxt;
            tx_irq_r <= tx_irq_nxt;
            line_r <= line_nxt;
            rx_state_r <= rx_state_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_pbit_r <= rx_pbit_nxt;
            ovr_r <= ovr_nxt;
            rx_irq_r <= rx_irq_nxt;
            err_irq_r <= err_irq_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_break_stop;
        ce_i && frame_end && tx_brk_r && !send_break_set_i;
    endsequence
    sequence s_ovr_clear;
        ce_i && ovr_r && overrun_clear_i;
    endsequence

    a_txen_order: assert property (ce_i && tx_enable_i && !txreq_q_r && !module_enable_i
        |=> !txen_r) else $error("tx enabled before module"); // [RULE1]
    a_txen_flag: assert property (ce_i && txen_nxt && !txen_r
        |=> tx_irq_flag_o) else $error("tx enable did not raise flag"); // [RULE2]
    a_break_low: assert property (tx_brk_r && tx_state_r == TX_DATA
        |-> !serial_output_line_o) else $error("break bit not low"); // [RULE4]
    a_break_clear: assert property (s_break_stop
        |=> !send_break_o && shift_empty_flag_o) else $error("break not cleared"); // [RULE6]
    a_break_quiet: assert property (ce_i && tx_brk_r && tx_state_r != TX_IDLE && !tx_irq_r
        |=> !tx_irq_flag_o) else $error("break raised tx flag"); // [RULE8]
    a_shift_loaded: assert property (ce_i && load
        |=> !shift_empty_flag_o) else $error("shift empty after load"); // [RULE10]
    a_line_idle: assert property (tx_state_r == TX_IDLE
        |-> serial_output_line_o) else $error("line low while idle"); // [RULE25]
    a_overrun_set: assert property (ce_i && module_enable_i && stop_evt && !rxw.ready
        && !ovr_r |=> rx_status_o[STAT_OVR]) else $error("overrun missed"); // [RULE16]
    a_overrun_hold: assert property (ovr_r && $past(ovr_r)
        |-> !rx_irq_o && !rxw.valid) else $error("transfer during overrun"); // [RULE17]
    a_overrun_flush: assert property (s_ovr_clear
        |=> !rx_status_o[STAT_AVAIL] ##1 !ovr_r) else $error("fifo kept after clear"); // [RULE18]
    a_avail_push: assert property (ce_i && module_enable_i && rxw.valid && rxw.ready
        |=> rx_status_o[STAT_AVAIL]) else $error("word pushed, none available"); // [RULE24]
    a_framing_error_flag_head: assert property (ce_i && module_enable_i && rxw.valid && rx_count == 3'h0
        && !rbit |=> rx_status_o[STAT_FRAMING_ERROR_FLAG]) else $error("framing flag lost"); // [RULE19]
endmodule // uart_core
`default_nettype wire

// [src/uart_pkg.sv]
`default_nettype none
package uart_pkg;
    // Oversampling: last sub-bit index per bit time
    localparam logic [3:0] OVS_LO_LAST = 4'hF;
    localparam logic [3:0] OVS_HI_LAST = 4'h3;
    // 16x vote edges 7, 8 and 9 (sub index is edge minus one)
    localparam logic [3:0] VOTE_A = 4'h6;
    localparam logic [3:0] VOTE_B = 4'h7;
    localparam logic [3:0] VOTE_C = 4'h8;
    // 4x: half of a four-tick bit
    localparam logic [3:0] MID_HI = 4'h1;
    localparam logic [3:0] BRK_ZEROS = 4'hC;
    localparam logic [3:0] BITS8 = 4'h8;
    localparam logic [3:0] BITS9 = 4'h9;
    localparam int WORD_W = 9;
    localparam int ENTRY_W = 11;
    localparam int FRAMING_ERROR_FLAG_POS = 9;
    localparam int PARITY_ERROR_FLAG_POS = 10;
    localparam int TX_DEPTH = 2;
    localparam int RX_DEPTH = 4;
    localparam logic [2:0] RX_FULL = 3'h4;
    // Status vector bit positions
    localparam int STAT_AVAIL = 0;
    localparam int STAT_OVR = 1;
    localparam int STAT_FRAMING_ERROR_FLAG = 2;
    localparam int STAT_PARITY_ERROR_FLAG = 3;
    localparam logic [1:0] FMT_8N = 2'h0;
    localparam logic [1:0] FMT_8E = 2'h1;
    localparam logic [1:0] FMT_8O = 2'h2;
    localparam logic [1:0] FMT_9N = 2'h3;
    localparam logic [1:0] TXSEL_LOAD = 2'h0;
    localparam logic [1:0] TXSEL_DONE = 2'h1;
    localparam logic [1:0] TXSEL_EMPTY = 2'h2;

    function automatic logic parity_bit(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction
endpackage
`default_nettype wire

// [src/stream_if.sv]
`default_nettype none
interface stream_if #(parameter int W = 9) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// [src/word_fifo.sv]
`default_nettype none
module word_fifo import uart_pkg::*; #(
    parameter int W = WORD_W,
    parameter int DEPTH = TX_DEPTH
) (
    // Clock and control
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic flush_i,
    // Streams
    stream_if.snk in_s,
    stream_if.src out_s,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_s.ready = cnt_r != CW'(DEPTH);
    assign out_s.valid = cnt_r != '0;
    assign out_s.data = mem_r[rp_r];
    assign count_o = cnt_r;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.ready && out_s.valid;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (flush_i) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                mem_nxt[wp_r] = in_s.data;
                wp_nxt = wp_r + 1'b1;
            end
            if (pop) begin
                rp_nxt = rp_r + 1'b1;
            end
            cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mem_r <= '{default: '0};
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (ce_i) begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule // word_fifo
`default_nettype wire

// [src/rx_sampler.sv]
`default_nettype none
module rx_sampler import uart_pkg::*; (
    // Clock and control
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic active_i,
    input wire logic tick_i,
    input wire logic high_speed_i,
    // Line
    input wire logic serial_i,
    // Recovered bits
    output logic start_o,
    output logic strobe_o,
    output logic bit_o
);
    logic s1_r, s2_r, s3_r;
    logic level_r, level_nxt, prev_r;
    logic va_r, va_nxt, vb_r, vb_nxt;
    logic [3:0] sub_r, sub_nxt;
    logic [3:0] last;

    assign last = high_speed_i ? OVS_HI_LAST : OVS_LO_LAST;

    always_comb begin
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
        sub_nxt = sub_r;
        va_nxt = va_r;
        vb_nxt = vb_r;
        if (!active_i) begin
            sub_nxt = 4'h0;
        end else if (tick_i) begin
            sub_nxt = (sub_r == last) ? 4'h0 : sub_r + 4'h1;
            if (sub_r == VOTE_A) va_nxt = level_r; // [RULE12]
            if (sub_r == VOTE_B) vb_nxt = level_r; // [RULE12]
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_r <= 1'b1;
            prev_r <= 1'b1;
            va_r <= 1'b1;
            vb_r <= 1'b1;
            sub_r <= 4'h0;
        end else if (ce_i) begin
            s1_r <= serial_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            prev_r <= level_r;
            va_r <= va_nxt;
            vb_r <= vb_nxt;
            sub_r <= sub_nxt;
        end
    end

    assign start_o = run_i && !active_i && prev_r && !level_r;
    // Single mid-bit sample in 4x, vote on edges 7..9 in 16x
    assign strobe_o = active_i && tick_i && sub_r == (high_speed_i ? MID_HI : VOTE_C); // [RULE13]
    assign bit_o = high_speed_i ? level_r
                 : (va_r & vb_r) | (va_r & level_r) | (vb_r & level_r); // [RULE12]
endmodule // rx_sampler
`default_nettype wire

// [tb/uart_peer.sv]
`default_nettype none
module uart_peer (
    // Clock
    input wire logic clock_i,
    // Line toward the receiver
    output logic serial_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle line is a mark, so the far side rests high between frames
    initial serial_o = 1'b1;

    // Bits go out LSB first, each held for bt clocks
    task automatic send(input logic [15:0] bits, input int n, input int bt);
        for (int i = 0; i < n; i++) begin
            serial_o = bits[i];
            repeat (bt) @(posedge clock_i);
            #5;
        end
        serial_o = 1'b1;
    endtask
endmodule // uart_peer
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic mod_en = 1'b0, tx_en = 1'b0, hs = 1'b0, eie = 1'b1;
    logic [1:0] fmt = 2'h0, tis = 2'h1;
    logic [4:0] pv = 5'h00;
    logic [8:0] txd = 9'h000;
    logic [8:0] rxd;
    logic [3:0] stat;
    logic brk, tflag, tfull, sempty, rxirq, errirq, line_rx, line_tx, oe;
    int miscompares = 0, n_tests = 0, cycles = 0, n_err = 0, n_push = 0;

    uart_core i_uart_core(.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
        .module_enable_i(mod_en), .tx_enable_i(tx_en), .high_speed_select_i(hs),
        .format_parity_select_i(fmt), .stop_count_select_i(1'b0),
        .tx_irq_select_i(tis), .baud_divisor_i(16'h0000), .error_irq_enable_i(eie),
        .send_break_set_i(pv[0]), .tx_irq_clear_i(pv[1]), .tx_write_i(pv[4]),
        .tx_data_i(txd), .send_break_o(brk), .tx_irq_flag_o(tflag),
        .tx_full_flag_o(tfull), .shift_empty_flag_o(sempty), .rx_read_i(pv[2]),
        .overrun_clear_i(pv[3]), .rx_data_o(rxd), .rx_status_o(stat),
        .rx_irq_o(rxirq), .error_irq_o(errirq), .serial_input_line_i(line_rx),
        .serial_output_line_o(line_tx), .serial_output_oe_o(oe));
    uart_peer i_uart_peer(.clock_i(clock_i), .serial_o(line_rx));

    initial forever #50 clock_i = ~clock_i;

    // Receive and error interrupt outputs are one-cycle pulses, so they are tallied every edge
    always @(posedge clock_i) begin
        cycles++;
        n_err += int'(errirq === 1'b1);
        n_push += int'(rxirq === 1'b1);
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t ns: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #5;
    endtask

    // Strobes: 0 break set, 1 tx flag clear, 2 rx read, 3 overrun clear, 4 write
    task automatic pulse(input logic [4:0] m);
        pv = m;
        cyc(1);
        pv = 5'h00;
    endtask

    // Samples mid-bit, one bit time apart
    task automatic line_is(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            chk(16'(line_tx), 16'(bits[i]));
            cyc(16);
        end
    endtask

    task automatic rx_is(input logic [8:0] d, input logic [3:0] s);
        chk(16'(rxd), 16'(d));
        chk(16'(stat), 16'(s));
    endtask

    task complete_run;
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        cyc(4);
        rst_i = 1'b0;
        chk({oe, line_tx, sempty, tfull, stat}, 16'h0060);
        tx_en = 1'b1;
        cyc(1);
        mod_en = 1'b1;
        cyc(2);
        chk({oe, tflag}, 16'h0000);
        tx_en = 1'b0;
        cyc(1);
        tx_en = 1'b1;
        cyc(1);
        chk({oe, tflag}, 16'h0003);
        pulse(5'h02);
        txd = 9'h0A5;
        pulse(5'h10);
        cyc(7);
        chk(16'(tflag), 16'h0000);
        line_is({1'b1, 8'hA5, 1'b0}, 10);
        chk({sempty, tflag, line_tx}, 16'h0007);
        tis = 2'h0;
        pulse(5'h02);
        pulse(5'h01);
        chk(16'(brk), 16'h0001);
        cyc(1);
        txd = 9'h1FF;
        pulse(5'h10);
        cyc(1);
        txd = 9'h055;
        pulse(5'h10);
        cyc(6);
        chk({brk, sempty, tflag}, 16'h0004);
        // The sync byte is already queued, so any leak would show here
        line_is({1'b1, 13'h0000}, 14);
        chk({brk, tflag}, 16'h0001);
        line_is({1'b1, 8'h55, 1'b0}, 10);
        txd = 9'h0F0;
        tis = 2'h2;
        pv = 5'h12;
        cyc(1);
        pv = 5'h00;
        cyc(1);
        chk(16'(tflag), 16'h0001);
        pv = 5'h10;
        cyc(2);
        pv = 5'h00;
        chk(16'(tfull), 16'h0001);
        mod_en = 1'b0;
        cyc(1);
        chk({tfull, line_tx, sempty}, 16'h0003);
        mod_en = 1'b1;
        for (int i = 0; i < 5; i++) i_uart_peer.send({1'b1, 8'h11 + 8'(i), 1'b0}, 10, 16);
        cyc(4);
        rx_is(9'h011, 4'h3);
        chk(16'(n_push), 16'h0004);
        pulse(5'h04);
        rx_is(9'h012, 4'h3);
        cyc(1);
        pulse(5'h08);
        chk(16'(stat), 16'h0000);
        i_uart_peer.send({1'b0, 8'h3C, 1'b0}, 10, 16);
        cyc(4);
        rx_is(9'h03C, 4'h5);
        pulse(5'h04);
        fmt = 2'h1;
        i_uart_peer.send({1'b1, 1'b0, 8'h07, 1'b0}, 11, 16);
        i_uart_peer.send({1'b1, 1'b1, 8'h07, 1'b0}, 11, 16);
        cyc(4);
        rx_is(9'h007, 4'h9);
        pulse(5'h04);
        rx_is(9'h007, 4'h1);
        cyc(1);
        pulse(5'h04);
        chk(16'(stat), 16'h0000);
        chk(16'(n_err), 16'h0003);
        fmt = 2'h0;
        hs = 1'b1;
        eie = 1'b0;
        cyc(1);
        i_uart_peer.send({1'b0, 8'h9C, 1'b0}, 10, 4);
        cyc(4);
        rx_is(9'h09C, 4'h5);
        chk(16'(n_err), 16'h0003);
        complete_run();
    end
endmodule // tb
`default_nettype wire
